/* rtl/hdl_core.sv */
// Holdover, tuning DAC and lock-detect control with serial register access.
module hdl_core #(
   parameter int CNT_W = 14,
   parameter int DAC_W = 10
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic uwire_clk,
   input wire logic uwire_data,
   input wire logic uwire_le,
   output logic uwire_readback,
   input wire logic pd1_tick,
   input wire logic pd2_tick,
   input wire logic [7:0] loop1_phase_err,
   input wire logic [7:0] loop2_phase_err,
   input wire logic [DAC_W-1:0] loop1_vtune,
   output logic [DAC_W-1:0] tuning_dac,
   output logic dac_update,
   output logic loop1_lock_detect,
   output logic loop2_lock_detect,
   output logic holdover_active,
   output logic rail_trip
);

   // ****************************************
   // Serial register interface.
   // ****************************************
   // Words shift in MSB first; the low five bits carry the address and
   // the word is committed on the rising edge of the latch enable.

   logic [31:0] regs_r [32];
   logic [31:0] regs_nxt [32];
   logic [31:0] shift_r;
   logic [31:0] shift_nxt;
   logic [31:0] rb_r;
   logic [31:0] rb_nxt;
   logic uclk_prev_r;
   logic le_prev_r;
   logic uclk_rise;
   logic le_rise;
   logic [4:0] wr_addr;
   logic [4:0] rb_sel;
   logic [DAC_W-1:0] dac_value;

   assign uclk_rise = uwire_clk && !uclk_prev_r;
   assign le_rise = uwire_le && !le_prev_r;
   assign wr_addr = shift_r[hdl_pkg::ADDR_LSB +: hdl_pkg::ADDR_W];
   assign rb_sel = shift_r[hdl_pkg::RB_ADDR_LSB +: hdl_pkg::ADDR_W];

   function automatic logic [31:0] read_word(
      input logic [4:0] a,
      input logic [31:0] stored,
      input logic [DAC_W-1:0] dac
   );
      logic [31:0] w;
      w = stored;
      if (a == hdl_pkg::ADDR_MANUAL_DAC_AND_HOLDOVER_COUNT) begin
         w[hdl_pkg::MANUAL_DAC_LSB +: DAC_W] = dac;
      end
      if (!hdl_pkg::hdl_is_mapped(a)) begin
         w = '0;
      end
      read_word = w;
   endfunction

   always_comb begin
      regs_nxt = regs_r;
      shift_nxt = shift_r;
      rb_nxt = rb_r;
      if (uclk_rise && !uwire_le) begin
         shift_nxt = {shift_r[30:0], uwire_data};
         rb_nxt = {rb_r[30:0], 1'b0};
      end
      if (le_rise) begin
         if (hdl_pkg::hdl_is_mapped(wr_addr)) begin
            regs_nxt[wr_addr] = {shift_r[31:5], 5'h00};
         end
         // The copy is taken from the registers as they stand before this
         // commit, so a word written in the same frame is not seen yet.
         if (wr_addr == hdl_pkg::ADDR_READBACK_SELECT) begin
            rb_nxt = read_word(rb_sel,
                               regs_r[rb_sel],
                               dac_value);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < 32; i++) begin
            regs_r[i] <= hdl_pkg::hdl_reset_value(5'(i));
         end
         shift_r <= '0;
         rb_r <= '0;
         uclk_prev_r <= 1'b0;
         le_prev_r <= 1'b0;
      end else if (ce) begin
         regs_r <= regs_nxt;
         shift_r <= shift_nxt;
         rb_r <= rb_nxt;
         uclk_prev_r <= uwire_clk;
         le_prev_r <= uwire_le;
      end
   end

   assign uwire_readback = rb_r[31];

   // ****************************************
   // Field decode.
   // ****************************************

   hdl_pkg::hdl_cfg_s cfg;
   logic [31:0] r_mode;
   logic [31:0] r_pin;
   logic [31:0] r_trip;
   logic [31:0] r_man;
   logic [31:0] r_filt;
   logic [31:0] r_div;
   logic [31:0] r_loop2;

   assign r_mode = regs_r[hdl_pkg::ADDR_MODE_CONTROL];
   assign r_pin = regs_r[hdl_pkg::ADDR_STATUS_PIN_CONTROL];
   assign r_trip = regs_r[hdl_pkg::ADDR_CLOCK_INPUT_LOSS_AND_DAC_TRIP];
   assign r_man = regs_r[hdl_pkg::ADDR_MANUAL_DAC_AND_HOLDOVER_COUNT];
   assign r_filt = regs_r[hdl_pkg::ADDR_LOOP_FILTER_AND_FEEDBACK_DELAY];
   assign r_div = regs_r[hdl_pkg::ADDR_DAC_DIVIDER_AND_FIRST_LOCK_COUNT];
   assign r_loop2 = regs_r[hdl_pkg::ADDR_SECOND_LOOP_PUMP_AND_LOCK];

   always_comb begin
      cfg.track_en = r_mode[hdl_pkg::TRACK_EN_BIT];
      cfg.lock_loss_mask = r_pin[hdl_pkg::LOCK_LOSS_MASK_BIT];
      cfg.high_trip = r_trip[hdl_pkg::HIGH_TRIP_LSB +: hdl_pkg::TRIP_W];
      cfg.low_trip = r_trip[hdl_pkg::LOW_TRIP_LSB +: hdl_pkg::TRIP_W];
      cfg.rail_det_en = r_trip[hdl_pkg::RAIL_DET_BIT];
      cfg.manual_value = r_man[hdl_pkg::MANUAL_DAC_LSB +: hdl_pkg::DAC_W];
      cfg.override_en = r_man[hdl_pkg::OVERRIDE_BIT];
      cfg.holdover_exit_count = r_man[hdl_pkg::COUNT_LSB +: hdl_pkg::COUNT_W];
      cfg.force_holdover = r_man[hdl_pkg::FORCE_HOLD_BIT];
      cfg.loop1_window = r_filt[hdl_pkg::LOOP1_WIN_LSB +: hdl_pkg::WIN_W];
      cfg.dac_divisor = r_div[hdl_pkg::DAC_DIV_LSB +: hdl_pkg::DAC_W];
      cfg.loop1_count = r_div[hdl_pkg::COUNT_LSB +: hdl_pkg::COUNT_W];
      cfg.loop2_window = r_loop2[hdl_pkg::LOOP2_WIN_LSB +: hdl_pkg::WIN_W];
      cfg.loop2_count = r_loop2[hdl_pkg::COUNT_LSB +: hdl_pkg::COUNT_W];
   end

   // ****************************************
   // Window comparison and rail trip.
   // ****************************************

   logic loop1_in_win;
   logic loop2_in_win;
   logic trip_hi;
   logic trip_lo;
   logic [DAC_W-1:0] hi_point;

   assign loop1_in_win =
      loop1_phase_err <= hdl_pkg::LOOP1_WIN_NS[cfg.loop1_window];
   // The reserved code never qualifies, so the lock stays low.
   assign loop2_in_win =
      (cfg.loop2_window != hdl_pkg::LOOP2_WIN_RESERVED) &&
      (loop2_phase_err <= hdl_pkg::LOOP2_WIN_NS[cfg.loop2_window]);

   assign hi_point = hdl_pkg::DAC_FULL_SCALE - DAC_W'(cfg.high_trip);
   assign trip_hi = dac_value >= hi_point;
   assign trip_lo = dac_value <= DAC_W'(cfg.low_trip);
   assign rail_trip = cfg.rail_det_en && (trip_hi || trip_lo);

   // ****************************************
   // Lock qualification.
   // ****************************************

   logic loop1_qual;
   logic loop2_qual;
   logic exit_qual;
   hdl_pkg::hdl_state_e state_r;
   hdl_pkg::hdl_state_e state_nxt;

   hdl_lock_qual #(.CNT_W(CNT_W)) u_loop1_qual (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .tick(pd1_tick),
      .in_window(loop1_in_win),
      .target(cfg.loop1_count),
      .qualified(loop1_qual)
   );

   hdl_lock_qual #(.CNT_W(CNT_W)) u_loop2_qual (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .tick(pd2_tick),
      .in_window(loop2_in_win),
      .target(cfg.loop2_count),
      .qualified(loop2_qual)
   );

   // Counts only while in holdover, so every exit starts a fresh count.
   hdl_lock_qual #(.CNT_W(CNT_W)) u_exit_qual (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .tick(pd1_tick),
      .in_window(loop1_in_win && !rail_trip &&
                 (state_r == hdl_pkg::HDL_ST_HOLDOVER)),
      .target(cfg.holdover_exit_count),
      .qualified(exit_qual)
   );

   // ****************************************
   // Holdover control.
   // ****************************************

   logic lock1_r;
   logic lock1_nxt;
   logic lock1_fall;

   assign lock1_nxt = loop1_qual && !rail_trip;
   assign lock1_fall = lock1_r && !lock1_nxt;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         hdl_pkg::HDL_ST_TRACKING: begin
            if (cfg.force_holdover ||
                (lock1_fall && !cfg.lock_loss_mask)) begin
               state_nxt = hdl_pkg::HDL_ST_HOLDOVER;
            end
         end
         hdl_pkg::HDL_ST_HOLDOVER: begin
            if (!cfg.force_holdover && exit_qual) begin
               state_nxt = hdl_pkg::HDL_ST_TRACKING;
            end
         end
         default: begin
            state_nxt = hdl_pkg::HDL_ST_TRACKING;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_r <= hdl_pkg::HDL_ST_TRACKING;
         lock1_r <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         lock1_r <= lock1_nxt;
      end
   end

   // ****************************************
   // Tuning DAC.
   // ****************************************

   hdl_dac_track #(.DAC_W(DAC_W)) u_dac (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .tick(pd1_tick),
      .divisor(cfg.dac_divisor),
      .override_en(cfg.override_en),
      .manual_value(cfg.manual_value),
      .track_en(cfg.track_en),
      .hold(state_r == hdl_pkg::HDL_ST_HOLDOVER),
      .vtune(loop1_vtune),
      .dac_value(dac_value),
      .dac_update(dac_update)
   );

   assign tuning_dac = dac_value;
   assign loop1_lock_detect = lock1_r;
   assign loop2_lock_detect = loop2_qual;
   assign holdover_active = (state_r == hdl_pkg::HDL_ST_HOLDOVER);

endmodule

/* common/hdl_pkg.sv */
// Package with register map, field layout, reset values and shared types.
package hdl_pkg;

   // ****************************************
   // Register addresses.
   // ****************************************
   localparam logic [4:0] ADDR_MODE_CONTROL = 5'h0C;
   localparam logic [4:0] ADDR_STATUS_PIN_CONTROL = 5'h0D;
   localparam logic [4:0] ADDR_CLOCK_INPUT_LOSS_AND_DAC_TRIP = 5'h0E;
   localparam logic [4:0] ADDR_MANUAL_DAC_AND_HOLDOVER_COUNT = 5'h0F;
   localparam logic [4:0] ADDR_CRYSTAL_DRIVE_LEVEL = 5'h10;
   localparam logic [4:0] ADDR_LOOP_FILTER_AND_FEEDBACK_DELAY = 5'h18;
   localparam logic [4:0] ADDR_DAC_DIVIDER_AND_FIRST_LOCK_COUNT = 5'h19;
   localparam logic [4:0] ADDR_SECOND_LOOP_PUMP_AND_LOCK = 5'h1A;
   localparam logic [4:0] ADDR_FIRST_LOOP_PUMP_AND_REFERENCE = 5'h1B;
   localparam logic [4:0] ADDR_READBACK_SELECT = 5'h1F;

   // ****************************************
   // Field positions.
   // ****************************************
   localparam int ADDR_LSB = 0;
   localparam int ADDR_W = 5;
   localparam int TRACK_EN_BIT = 8;
   localparam int LOCK_LOSS_MASK_BIT = 15;
   localparam int HIGH_TRIP_LSB = 14;
   localparam int LOW_TRIP_LSB = 6;
   localparam int TRIP_W = 6;
   localparam int RAIL_DET_BIT = 5;
   localparam int MANUAL_DAC_LSB = 22;
   localparam int DAC_W = 10;
   localparam int OVERRIDE_BIT = 20;
   localparam int COUNT_LSB = 6;
   localparam int COUNT_W = 14;
   localparam int FORCE_HOLD_BIT = 5;
   localparam int LOOP1_WIN_LSB = 6;
   localparam int LOOP2_WIN_LSB = 30;
   localparam int WIN_W = 2;
   localparam int DAC_DIV_LSB = 22;
   localparam int RB_ADDR_LSB = 16;

   // ****************************************
   // Reset values.
   // ****************************************
   localparam logic [31:0] RST_MODE_CONTROL = 32'h0000_0180;
   localparam logic [31:0] RST_MANUAL_DAC = 32'h8000_8000;
   localparam logic [31:0] RST_LOOP_FILTER = 32'h0000_00C0;
   localparam logic [31:0] RST_DAC_DIVIDER = 32'h0101_0000;
   localparam logic [31:0] RST_SECOND_LOOP = 32'h0C08_0000;
   localparam logic [31:0] RST_FIRST_LOOP = 32'h1000_1800;
   localparam logic [31:0] RST_READBACK = 32'h001F_0000;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [9:0] DAC_MID_SCALE = 10'h200;
   localparam logic [9:0] DAC_FULL_SCALE = 10'h3FF;

   // ****************************************
   // Lock windows in ns of phase error, one per code.
   // ****************************************
   localparam int WIN_TIME_NS_W = 8;
   localparam logic [7:0] LOOP1_WIN_NS [4] = '{8'h0A, 8'h14, 8'h1E, 8'h28};
   localparam logic [7:0] LOOP2_WIN_NS [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
   localparam logic [1:0] LOOP2_WIN_RESERVED = 2'h0;

   typedef enum logic [1:0] {
      HDL_ST_TRACKING = 2'b01,
      HDL_ST_HOLDOVER = 2'b10
   } hdl_state_e;

   typedef struct packed {
      logic track_en;
      logic lock_loss_mask;
      logic [5:0] high_trip;
      logic [5:0] low_trip;
      logic rail_det_en;
      logic [9:0] manual_value;
      logic override_en;
      logic [13:0] holdover_exit_count;
      logic force_holdover;
      logic [1:0] loop1_window;
      logic [9:0] dac_divisor;
      logic [13:0] loop1_count;
      logic [1:0] loop2_window;
      logic [13:0] loop2_count;
   } hdl_cfg_s;

   function automatic logic hdl_is_mapped(input logic [4:0] a);
      case (a)
         ADDR_MODE_CONTROL, ADDR_STATUS_PIN_CONTROL,
         ADDR_CLOCK_INPUT_LOSS_AND_DAC_TRIP,
         ADDR_MANUAL_DAC_AND_HOLDOVER_COUNT, ADDR_CRYSTAL_DRIVE_LEVEL,
         ADDR_LOOP_FILTER_AND_FEEDBACK_DELAY,
         ADDR_DAC_DIVIDER_AND_FIRST_LOCK_COUNT,
         ADDR_SECOND_LOOP_PUMP_AND_LOCK, ADDR_FIRST_LOOP_PUMP_AND_REFERENCE,
         ADDR_READBACK_SELECT: hdl_is_mapped = 1'b1;
         default: hdl_is_mapped = 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] hdl_reset_value(input logic [4:0] a);
      case (a)
         ADDR_MODE_CONTROL: hdl_reset_value = RST_MODE_CONTROL;
         ADDR_MANUAL_DAC_AND_HOLDOVER_COUNT: hdl_reset_value = RST_MANUAL_DAC;
         ADDR_LOOP_FILTER_AND_FEEDBACK_DELAY: hdl_reset_value = RST_LOOP_FILTER;
         ADDR_DAC_DIVIDER_AND_FIRST_LOCK_COUNT: hdl_reset_value = RST_DAC_DIVIDER;
         ADDR_SECOND_LOOP_PUMP_AND_LOCK: hdl_reset_value = RST_SECOND_LOOP;
         ADDR_FIRST_LOOP_PUMP_AND_REFERENCE: hdl_reset_value = RST_FIRST_LOOP;
         ADDR_READBACK_SELECT: hdl_reset_value = RST_READBACK;
         default: hdl_reset_value = RST_ZERO;
      endcase
   endfunction

endpackage

/* rtl/hdl_lock_qual.sv */
// Lock qualification counter: counts detector ticks spent inside a window.
module hdl_lock_qual #(
   parameter int CNT_W = 14
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic tick,
   input wire logic in_window,
   input wire logic [CNT_W-1:0] target,
   output logic qualified
);

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic qual_r;
   logic qual_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (!in_window) begin
         cnt_nxt = '0;
      end else if (tick && (cnt_r < target)) begin
         cnt_nxt = cnt_r + 1'b1;
      end
      qual_nxt = in_window && (cnt_nxt >= target);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_r <= '0;
         qual_r <= 1'b0;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
         qual_r <= qual_nxt;
      end
   end

   assign qualified = qual_r;

endmodule

/* rtl/hdl_dac_track.sv */
// Tuning DAC with update-rate divider, tracking and manual override.
module hdl_dac_track #(
   parameter int DAC_W = 10
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic tick,
   input wire logic [DAC_W-1:0] divisor,
   input wire logic override_en,
   input wire logic [DAC_W-1:0] manual_value,
   input wire logic track_en,
   input wire logic hold,
   input wire logic [DAC_W-1:0] vtune,
   output logic [DAC_W-1:0] dac_value,
   output logic dac_update
);

   logic [DAC_W-1:0] div_r;
   logic [DAC_W-1:0] div_nxt;
   logic [DAC_W-1:0] dac_r;
   logic [DAC_W-1:0] dac_nxt;
   logic upd_r;
   logic upd_nxt;

   always_comb begin
      div_nxt = div_r;
      dac_nxt = dac_r;
      upd_nxt = 1'b0;
      if (tick) begin
         // A divisor of zero behaves as divide-by-one.
         if ((div_r + 1'b1) >= divisor) begin
            div_nxt = '0;
            upd_nxt = 1'b1;
            if (override_en) begin
               dac_nxt = manual_value;
            end else if (track_en && !hold) begin
               dac_nxt = vtune;
            end
         end else begin
            div_nxt = div_r + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         div_r <= '0;
         dac_r <= hdl_pkg::DAC_MID_SCALE;
         upd_r <= 1'b0;
      end else if (ce) begin
         div_r <= div_nxt;
         dac_r <= dac_nxt;
         upd_r <= upd_nxt;
      end
   end

   assign dac_value = dac_r;
   assign dac_update = upd_r;

endmodule

/* tb/hdl_core_assertions.sv */
// Port-level checker for the holdover, tuning DAC and lock-detect block.
module hdl_chk #(
   parameter int DAC_W = 10
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic pd1_tick,
   input wire logic pd2_tick,
   input wire logic [7:0] loop1_phase_err,
   input wire logic [7:0] loop2_phase_err,
   input wire logic [DAC_W-1:0] tuning_dac,
   input wire logic dac_update,
   input wire logic loop1_lock_detect,
   input wire logic loop2_lock_detect,
   input wire logic holdover_active,
   input wire logic rail_trip
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Timing relations seen at the ports.
   // ****************************************
   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   // An error beyond the widest window of each loop.
   sequence loop1_out_s;
      pd1_tick && loop1_phase_err > 8'h28;
   endsequence
   sequence loop2_out_s;
      pd2_tick && loop2_phase_err > 8'h0C;
   endsequence

   reset_state_a: assert property (disable iff (1'b0)
      sys_rst |=> tuning_dac == 10'h200 && !holdover_active && !dac_update)
      else $error("tuning value or holdover wrong after reset");
   dac_tick_a: assert property (dac_update |-> $past(pd1_tick))
      else $error("tuning update without a detector tick");
   dac_gate_a: assert property ($changed(tuning_dac) |->
      dac_update || $past(dac_update))
      else $error("tuning value changed outside an update");
   rail_lock_a: assert property (rail_trip |=> !loop1_lock_detect)
      else $error("first loop lock held during a rail trip");
   loop1_drop_a: assert property (loop1_out_s |->
      ##[1:3] !loop1_lock_detect)
      else $error("first loop lock kept after leaving window");
   loop2_drop_a: assert property (loop2_out_s |->
      ##[1:3] !loop2_lock_detect)
      else $error("second loop lock kept after leaving window");
   loop1_rise_a: assert property ($rose(loop1_lock_detect) |->
      !$past(rail_trip) && ($past(loop1_phase_err) <= 8'h28 ||
      $past(loop1_phase_err, 2) <= 8'h28))
      else $error("first loop lock rose outside its window");
   loop2_rise_a: assert property ($rose(loop2_lock_detect) |->
      $past(loop2_phase_err) <= 8'h0C || $past(loop2_phase_err, 2) <= 8'h0C)
      else $error("second loop lock rose outside its window");
endmodule

bind hdl_core hdl_chk #(.DAC_W(DAC_W)) u_chk (
   .sys_clk(sys_clk),
   .sys_rst(sys_rst),
   .pd1_tick(pd1_tick),
   .pd2_tick(pd2_tick),
   .loop1_phase_err(loop1_phase_err),
   .loop2_phase_err(loop2_phase_err),
   .tuning_dac(tuning_dac),
   .dac_update(dac_update),
   .loop1_lock_detect(loop1_lock_detect),
   .loop2_lock_detect(loop2_lock_detect),
   .holdover_active(holdover_active),
   .rail_trip(rail_trip)
);

/* tb/tb.sv */
// Self-checking bench for the holdover, tuning DAC and lock-detect block.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Stimulus, design and checking helpers.
   // ****************************************
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic uwire_clk = 1'b0;
   logic uwire_data = 1'b0;
   logic uwire_le = 1'b0;
   logic pd1_tick = 1'b0;
   logic pd2_tick = 1'b0;
   logic [7:0] loop1_phase_err = 8'h00;
   logic [7:0] loop2_phase_err = 8'h00;
   logic [9:0] loop1_vtune = 10'h200;
   logic uwire_readback;
   logic [9:0] tuning_dac;
   logic dac_update;
   logic loop1_lock_detect;
   logic loop2_lock_detect;
   logic holdover_active;
   logic rail_trip;
   int fail_count = 0;
   int n_checks = 0;
   int updates = 0;

   always #5 sys_clk = ~sys_clk;

   hdl_core dut (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .ce(1'b1),
      .uwire_clk(uwire_clk),
      .uwire_data(uwire_data),
      .uwire_le(uwire_le),
      .uwire_readback(uwire_readback),
      .pd1_tick(pd1_tick),
      .pd2_tick(pd2_tick),
      .loop1_phase_err(loop1_phase_err),
      .loop2_phase_err(loop2_phase_err),
      .loop1_vtune(loop1_vtune),
      .tuning_dac(tuning_dac),
      .dac_update(dac_update),
      .loop1_lock_detect(loop1_lock_detect),
      .loop2_lock_detect(loop2_lock_detect),
      .holdover_active(holdover_active),
      .rail_trip(rail_trip)
   );

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      if (fail_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   // Each serial clock level lasts one system cycle; latch pulse commits.
   task automatic wr(input logic [31:0] w);
      for (int i = 31; i >= 0; i--) begin
         uwire_data = w[i];
         uwire_clk = 1'b1;
         cyc(1);
         uwire_clk = 1'b0;
         cyc(1);
      end
      uwire_le = 1'b1;
      cyc(1);
      uwire_le = 1'b0;
      cyc(1);
   endtask

   task automatic rdchk(input string what, input logic [4:0] a,
                        input logic [31:0] exp);
      logic [31:0] v;
      wr({11'h000, a, 11'h000, 5'h1F});
      for (int i = 31; i >= 0; i--) begin
         v[i] = uwire_readback;
         uwire_clk = 1'b1;
         cyc(1);
         uwire_clk = 1'b0;
         cyc(1);
      end
      check(what, v, exp);
   endtask

   // Pulses both detector ticks and counts tuning updates seen meanwhile.
   task automatic tick(input int n);
      for (int i = 0; i < n; i++) begin
         pd1_tick = 1'b1;
         pd2_tick = 1'b1;
         cyc(1);
         updates += int'(dac_update);
         pd1_tick = 1'b0;
         pd2_tick = 1'b0;
         cyc(1);
         updates += int'(dac_update);
      end
      cyc(1);
      updates += int'(dac_update);
   endtask

   // ****************************************
   // Scenarios.
   // ****************************************
   task automatic t_reset();
      rdchk("trip", 5'h0E, 32'h0000_0000);
      rdchk("man", 5'h0F, {10'h200, 2'h0, 14'h0200, 6'h00});
      rdchk("win1", 5'h18, {24'h00_0000, 2'h3, 6'h00});
      rdchk("cnt1", 5'h19, {10'h004, 2'h0, 14'h0400, 6'h00});
      rdchk("cnt2", 5'h1A, {6'h03, 6'h00, 14'h2000, 6'h00});
      wr({27'h000_0FFF, 5'h05});
      rdchk("unmapped", 5'h05, 32'h0000_0000);
   endtask

   task automatic t_dac();
      wr({10'h155, 1'h0, 1'h1, 14'h0003, 1'h0, 5'h0F});
      updates = 0;
      tick(8);
      check("updates", 32'(updates), 32'h2);
      check("manual", 32'(tuning_dac), 32'h155);
      wr({10'h0AA, 2'h0, 14'h0003, 1'h0, 5'h0F});
      loop1_vtune = 10'h2C3;
      tick(4);
      check("track", 32'(tuning_dac), 32'h2C3);
      rdchk("readdac", 5'h0F, {10'h2C3, 2'h0, 14'h0003, 6'h00});
   endtask

   task automatic t_loop1();
      wr({10'h004, 2'h0, 14'h0005, 1'h0, 5'h19});
      loop1_phase_err = 8'h29;
      tick(1);
      loop1_phase_err = 8'h28;
      tick(4);
      loop1_phase_err = 8'h29;
      tick(1);
      loop1_phase_err = 8'h28;
      tick(4);
      check("restart1", 32'(loop1_lock_detect), 32'h0);
      tick(1);
      check("lock1", 32'(loop1_lock_detect), 32'h1);
   endtask

   task automatic t_hold();
      wr({10'h000, 2'h0, 14'h0003, 1'h0, 5'h0F});
      loop1_phase_err = 8'h29;
      tick(1);
      check("enter", 32'(holdover_active), 32'h1);
      loop1_phase_err = 8'h28;
      tick(2);
      check("stay", 32'(holdover_active), 32'h1);
      tick(1);
      check("leave", 32'(holdover_active), 32'h0);
      wr({10'h000, 2'h0, 14'h0003, 1'h1, 5'h0F});
      loop1_vtune = 10'h1A5;
      tick(8);
      check("forced", 32'(holdover_active), 32'h1);
      check("held", 32'(tuning_dac), 32'h2C3);
      wr({10'h000, 2'h0, 14'h0003, 1'h0, 5'h0F});
      check("release", 32'(holdover_active), 32'h0);
      tick(4);
      check("retrack", 32'(tuning_dac), 32'h1A5);
      tick(2);
      wr({16'h0000, 1'h1, 10'h000, 5'h0D});
      loop1_phase_err = 8'h29;
      tick(1);
      check("masked", 32'(holdover_active), 32'h0);
      loop1_phase_err = 8'h28;
   endtask

   task automatic t_rail();
      logic [9:0] vt [4] = '{10'h3C0, 10'h3C0, 10'h03F, 10'h03F};
      logic [5:0] hi [4] = '{6'h3F, 6'h3E, 6'h00, 6'h00};
      logic [5:0] lo [4] = '{6'h00, 6'h00, 6'h3F, 6'h3E};
      for (int k = 0; k < 4; k++) begin
         loop1_vtune = vt[k];
         wr({12'h000, hi[k], 2'h0, lo[k], 1'h1, 5'h0E});
         tick(10);
         check("rail", 32'(rail_trip), 32'(k % 2 == 0));
         check("raillock", 32'(loop1_lock_detect), 32'(k % 2));
      end
      wr({24'h00_0000, 2'h0, 1'h0, 5'h18});
      loop1_phase_err = 8'h0B;
      tick(1);
      check("narrow", 32'(loop1_lock_detect), 32'h0);
      loop1_phase_err = 8'h0A;
      tick(5);
      check("narrowlock", 32'(loop1_lock_detect), 32'h1);
   endtask

   task automatic t_loop2();
      loop2_phase_err = 8'h00;
      wr({6'h03, 6'h00, 14'h0003, 1'h0, 5'h1A});
      tick(4);
      check("reserved", 32'(loop2_lock_detect), 32'h0);
      for (int c = 1; c < 4; c++) begin
         wr({2'(c), 4'h3, 6'h00, 14'h0003, 1'h0, 5'h1A});
         loop2_phase_err = 8'(4 * c + 1);
         tick(1);
         check("out2", 32'(loop2_lock_detect), 32'h0);
         loop2_phase_err = 8'(4 * c);
         tick(2);
         check("early2", 32'(loop2_lock_detect), 32'h0);
         tick(1);
         check("lock2", 32'(loop2_lock_detect), 32'h1);
      end
   endtask

   initial begin
      cyc(50000);
      fail_count++;
      close_out();
   end

   initial begin
      cyc(10);
      sys_rst = 1'b0;
      cyc(1);
      t_reset();
      t_dac();
      t_loop1();
      t_hold();
      t_rail();
      t_loop2();
      close_out();
   end
endmodule
